// ---- logic/dtc_pkg.sv ----
// package: register map, field positions, modes and carriers of the dual timer/counter
package dtc_pkg;

	// register addresses on the special function register port
	localparam logic [7:0] DTC_ADDR_CTRL    = 8'h88;
	localparam logic [7:0] DTC_ADDR_MODE    = 8'h89;
	localparam logic [7:0] DTC_ADDR_T0_LO   = 8'h8a;
	localparam logic [7:0] DTC_ADDR_T1_LO   = 8'h8b;
	localparam logic [7:0] DTC_ADDR_T0_HI   = 8'h8c;
	localparam logic [7:0] DTC_ADDR_T1_HI   = 8'h8d;

	// control/status register bit positions
	localparam int DTC_T1_OVF_BIT  = 7;
	localparam int DTC_T1_RUN_BIT  = 6;
	localparam int DTC_T0_OVF_BIT  = 5;
	localparam int DTC_T0_RUN_BIT  = 4;
	localparam int DTC_X1_FLAG_BIT = 3;
	localparam int DTC_X1_TYPE_BIT = 2;
	localparam int DTC_X0_FLAG_BIT = 1;
	localparam int DTC_X0_TYPE_BIT = 0;

	// mode register bit positions (timer 0 in low nibble, timer 1 in high nibble)
	localparam int DTC_T1_GATE_BIT = 7;
	localparam int DTC_T1_CSEL_BIT = 6;
	localparam int DTC_T1_MODE_LSB = 4;
	localparam int DTC_T0_GATE_BIT = 3;
	localparam int DTC_T0_CSEL_BIT = 2;
	localparam int DTC_T0_MODE_LSB = 0;

	// reset values
	localparam logic [7:0] DTC_CTRL_RST   = 8'h00;
	localparam logic [7:0] DTC_MODE_RST   = 8'h00;
	localparam logic [7:0] DTC_COUNT_RST  = 8'h00;

	// timing: clocks per peripheral cycle, last divider count and mode 0 prescaler mask
	localparam int         DTC_CLK_PER_TICK = 6;
	localparam logic [2:0] DTC_TICK_LAST    = 3'(DTC_CLK_PER_TICK - 1);
	localparam logic [7:0] DTC_PRESC_MASK   = 8'h1f;
	localparam logic [7:0] DTC_BYTE_ONES    = 8'hff;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT  = 2'b00,
		DTC_MODE_16BIT  = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPECIAL = 2'b11
	} dtc_mode_e;

	// one timer's count pair with its overflow indication
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
		logic       ovf;
	} dtc_cnt_s;

	// register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} dtc_sfr_s;

	// interrupt vectoring acknowledges from the interrupt controller
	typedef struct packed {
		logic t1_ovf;
		logic x1;
		logic t0_ovf;
		logic x0;
	} dtc_ack_s;

	// pins: count inputs and active-low gate/interrupt inputs
	typedef struct packed {
		logic t1_count_pin;
		logic t0_count_pin;
		logic ext_irq1_pin_n;
		logic ext_irq0_pin_n;
	} dtc_pins_s;

endpackage

// ---- logic/dtc_timer.sv ----
// module: two timer/counters with shared control/status and mode registers
//
// Behaviour
// RL1 - t0 mode 3 splits into two bytes
// RL2 - t0 low byte keeps t0 controls
// RL3 - t0 high byte: timer, t1 run, t1 flag
// RL4 - each half overflows after 256-load counts
// RL5 - t1 mode 3 holds its count
// RL6 - t1 config high nibble, control bits 7,6
// RL7 - run enables; with gate, pin also governs
// RL8 - t1 rollover sets flag, requests interrupt
// RL9 - mode 0: 5-bit prescaler into high byte
// RL10 - mode 1: cascaded 16-bit count
// RL11 - mode 2: low byte reloads from high
// RL12 - t1 flag set on overflow, cleared on vectoring
// RL13 - t0 flag set hw, cleared vectoring/software
// RL14 - run bits start and stop timers
// RL15 - edge flags set on pin, cleared on processing
// RL16 - type bit: low level or falling edge
// RL17 - software uses t1 sparingly in split mode
// RL18 - software stops timer before mode change
// RL19 - t1 overflow gives serial baud tick
// RL20 - mode codes 00,01,10,11
// RL21 - gated count only while pin high
// RL22 - timer counts once per peripheral cycle
// RL23 - counter counts high-then-low pin samples
// RL24 - count bytes readable, writable to preset
module dtc_timer
	import dtc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire dtc_sfr_s   sfr,
	input  wire dtc_ack_s   irq_ack,
	input  wire dtc_pins_s  pins,
	output logic [7:0]      sfr_rdata,
	output logic            t0_irq,
	output logic            t1_irq,
	output logic            ext_irq0_req,
	output logic            ext_irq1_req,
	output logic            t1_baud_tick
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [2:0] presc;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic       t0_pin_smp;
		logic       t1_pin_smp;
		logic       x0_prev;
		logic       x1_prev;
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] t0_low_byte;
		logic [7:0] t0_high_byte;
		logic [7:0] t1_low_byte;
		logic [7:0] t1_high_byte;
		logic [7:0] rdata;
		logic       baud;
	} dtc_state_s;

	dtc_state_s st_r;
	dtc_state_s st_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// one count step of a timer in modes 0..2; mode 3 holds

	function automatic dtc_cnt_s cnt_step(input dtc_mode_e m, input logic [7:0] hi,
		input logic [7:0] lo, input logic inc);
		dtc_cnt_s   r;
		logic [4:0] p;
		logic [8:0] l9;
		logic [8:0] h9;
		r  = '{hi: hi, lo: lo, ovf: 1'b0};
		p  = 5'(lo + 8'h01);
		l9 = {1'b0, lo} + 9'h001;
		h9 = {1'b0, hi} + 9'h001;
		if (inc) begin
			case (m)
				DTC_MODE_13BIT: begin
					r.lo = (lo & ~DTC_PRESC_MASK) | {3'b000, p};  // see RL9
					if ((lo & DTC_PRESC_MASK) == DTC_PRESC_MASK) begin
						r.hi  = h9[7:0];
						r.ovf = h9[8];
					end
				end
				DTC_MODE_16BIT: begin
					r.lo = l9[7:0];  // see RL10
					if (l9[8]) begin
						r.hi  = h9[7:0];
						r.ovf = h9[8];
					end
				end
				DTC_MODE_RELOAD: begin
					r.lo  = l9[8] ? hi : l9[7:0];  // see RL11
					r.ovf = l9[8];
				end
				default: begin
					r = '{hi: hi, lo: lo, ovf: 1'b0};  // see RL5
				end
			endcase
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state

	logic       tick;
	logic       x0_lvl;
	logic       x1_lvl;
	logic       t0_fall;
	logic       t1_fall;
	logic       t0_go;
	logic       t1_go;
	logic       th0_go;
	logic       t0_split;
	logic [8:0] th0_9;
	logic [8:0] tl0_9;
	dtc_mode_e  t0_mode;
	dtc_mode_e  t1_mode;
	dtc_cnt_s   t0_res;
	dtc_cnt_s   t1_res;
	logic       t0_ovf;
	logic       t1_flag_set;
	logic       x0_set;
	logic       x1_set;

	always_comb begin
		st_nxt = st_r;

		// peripheral cycle divider
		tick = (st_r.presc == DTC_TICK_LAST);  // see RL22
		st_nxt.presc = tick ? 3'b000 : 3'(st_r.presc + 3'b001);

		// two-flop pin synchronisers
		st_nxt.sync1 = pins;
		st_nxt.sync2 = st_r.sync1;
		x0_lvl = st_r.sync2[0];
		x1_lvl = st_r.sync2[1];

		// count pin sampled once per peripheral cycle
		t0_fall = 1'b0;
		t1_fall = 1'b0;
		if (tick) begin
			st_nxt.t0_pin_smp = st_r.sync2[2];
			st_nxt.t1_pin_smp = st_r.sync2[3];
			t0_fall = st_r.t0_pin_smp & ~st_r.sync2[2];  // see RL23
			t1_fall = st_r.t1_pin_smp & ~st_r.sync2[3];  // see RL23
		end

		t0_mode  = dtc_mode_e'(st_r.mode[DTC_T0_MODE_LSB +: 2]);  // see RL20
		t1_mode  = dtc_mode_e'(st_r.mode[DTC_T1_MODE_LSB +: 2]);  // see RL6
		t0_split = (t0_mode == DTC_MODE_SPECIAL);  // see RL1

		// enables: run bit, optional gating by the interrupt pin, selected source
		t0_go = st_r.ctrl[DTC_T0_RUN_BIT]  // see RL14
			& (~st_r.mode[DTC_T0_GATE_BIT] | x0_lvl)  // see RL7, RL21
			& (st_r.mode[DTC_T0_CSEL_BIT] ? t0_fall : tick);  // see RL2
		// in split mode timer 1 has no run bit of its own and runs unless held in mode 3 or gated off by its interrupt pin
		t1_go = (st_r.ctrl[DTC_T1_RUN_BIT] | t0_split)  // see RL14, RL17
			& (~st_r.mode[DTC_T1_GATE_BIT] | x1_lvl)  // see RL21
			& (st_r.mode[DTC_T1_CSEL_BIT] ? t1_fall : tick);
		th0_go = st_r.ctrl[DTC_T1_RUN_BIT] & tick;  // see RL3

		// timer 0
		t0_res = cnt_step(t0_mode, st_r.t0_high_byte, st_r.t0_low_byte, t0_go);
		tl0_9  = {1'b0, st_r.t0_low_byte} + 9'h001;
		th0_9  = {1'b0, st_r.t0_high_byte} + 9'h001;
		if (t0_split) begin
			st_nxt.t0_low_byte  = t0_go ? tl0_9[7:0] : st_r.t0_low_byte;  // see RL4
			st_nxt.t0_high_byte = th0_go ? th0_9[7:0] : st_r.t0_high_byte;  // see RL4
			t0_ovf      = t0_go & tl0_9[8];
			t1_flag_set = th0_go & th0_9[8];  // see RL3
		end else begin
			st_nxt.t0_low_byte  = t0_res.lo;
			st_nxt.t0_high_byte = t0_res.hi;
			t0_ovf      = t0_res.ovf;
			t1_flag_set = 1'b0;
		end

		// timer 1
		t1_res = cnt_step(t1_mode, st_r.t1_high_byte, st_r.t1_low_byte, t1_go);
		st_nxt.t1_low_byte  = t1_res.lo;
		st_nxt.t1_high_byte = t1_res.hi;
		st_nxt.baud = t1_res.ovf;  // see RL19
		if (!t0_split) begin
			t1_flag_set = t1_res.ovf;  // see RL8
		end

		// external interrupt detection
		x0_set = st_r.ctrl[DTC_X0_TYPE_BIT] ? (st_r.x0_prev & ~x0_lvl) : ~x0_lvl;  // see RL16
		x1_set = st_r.ctrl[DTC_X1_TYPE_BIT] ? (st_r.x1_prev & ~x1_lvl) : ~x1_lvl;  // see RL16
		st_nxt.x0_prev = x0_lvl;
		st_nxt.x1_prev = x1_lvl;

		// register writes: software presets and control; presets win over counting, hardware flag events win over writes
		if (sfr.wr) begin
			case (sfr.addr)
				DTC_ADDR_CTRL:  st_nxt.ctrl = sfr.wdata;
				DTC_ADDR_MODE:  st_nxt.mode = sfr.wdata;
				DTC_ADDR_T0_LO: st_nxt.t0_low_byte  = sfr.wdata;  // see RL24
				DTC_ADDR_T0_HI: st_nxt.t0_high_byte = sfr.wdata;  // see RL24
				DTC_ADDR_T1_LO: st_nxt.t1_low_byte  = sfr.wdata;  // see RL24
				DTC_ADDR_T1_HI: st_nxt.t1_high_byte = sfr.wdata;  // see RL24
				default: begin
				end
			endcase
		end

		// vectoring acknowledges clear flags
		if (irq_ack.t1_ovf) begin
			st_nxt.ctrl[DTC_T1_OVF_BIT] = 1'b0;  // see RL12
		end
		if (irq_ack.t0_ovf) begin
			st_nxt.ctrl[DTC_T0_OVF_BIT] = 1'b0;  // see RL13
		end
		if (irq_ack.x0 && st_r.ctrl[DTC_X0_TYPE_BIT]) begin
			st_nxt.ctrl[DTC_X0_FLAG_BIT] = 1'b0;  // see RL15
		end
		if (irq_ack.x1 && st_r.ctrl[DTC_X1_TYPE_BIT]) begin
			st_nxt.ctrl[DTC_X1_FLAG_BIT] = 1'b0;  // see RL15
		end

		// level mode flag follows the pin; edge mode flag is sticky
		if (!st_r.ctrl[DTC_X0_TYPE_BIT]) begin
			st_nxt.ctrl[DTC_X0_FLAG_BIT] = x0_set;  // see RL16
		end else if (x0_set) begin
			st_nxt.ctrl[DTC_X0_FLAG_BIT] = 1'b1;  // see RL15
		end
		if (!st_r.ctrl[DTC_X1_TYPE_BIT]) begin
			st_nxt.ctrl[DTC_X1_FLAG_BIT] = x1_set;
		end else if (x1_set) begin
			st_nxt.ctrl[DTC_X1_FLAG_BIT] = 1'b1;  // see RL15
		end
		if (t1_flag_set) begin
			st_nxt.ctrl[DTC_T1_OVF_BIT] = 1'b1;  // see RL12
		end
		if (t0_ovf) begin
			st_nxt.ctrl[DTC_T0_OVF_BIT] = 1'b1;  // see RL13
		end

		// registered read data
		if (sfr.rd) begin
			case (sfr.addr)
				DTC_ADDR_CTRL:  st_nxt.rdata = st_r.ctrl;
				DTC_ADDR_MODE:  st_nxt.rdata = st_r.mode;
				DTC_ADDR_T0_LO: st_nxt.rdata = st_r.t0_low_byte;  // see RL24
				DTC_ADDR_T0_HI: st_nxt.rdata = st_r.t0_high_byte;
				DTC_ADDR_T1_LO: st_nxt.rdata = st_r.t1_low_byte;
				DTC_ADDR_T1_HI: st_nxt.rdata = st_r.t1_high_byte;
				default:        st_nxt.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= '{presc: 3'b000, sync1: 4'hf, sync2: 4'hf, t0_pin_smp: 1'b1,
				t1_pin_smp: 1'b1, x0_prev: 1'b1, x1_prev: 1'b1, ctrl: DTC_CTRL_RST,
				mode: DTC_MODE_RST, t0_low_byte: DTC_COUNT_RST,
				t0_high_byte: DTC_COUNT_RST, t1_low_byte: DTC_COUNT_RST,
				t1_high_byte: DTC_COUNT_RST, rdata: 8'h00, baud: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from flops

	assign sfr_rdata    = st_r.rdata;
	assign t0_irq       = st_r.ctrl[DTC_T0_OVF_BIT];
	assign t1_irq       = st_r.ctrl[DTC_T1_OVF_BIT];  // see RL8
	assign ext_irq0_req = st_r.ctrl[DTC_X0_FLAG_BIT];
	assign ext_irq1_req = st_r.ctrl[DTC_X1_FLAG_BIT];
	assign t1_baud_tick = st_r.baud;  // see RL19

endmodule

// ---- test/dtc_pins_model.sv ----
// model: drivers of the gate, interrupt and count pins
module dtc_pins_model
	import dtc_pkg::*;
(
	input  wire logic      clk,
	input  wire dtc_pins_s want,
	output dtc_pins_s      pins
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pins = '1;
	// levels follow the wanted value, updated on each rising clock edge
	always @(posedge clk) pins <= want;
endmodule

// ---- test/dtc_timer_sva.sv ----
// checker: port timing relations of the dual timer block
module dtc_timer_sva
	import dtc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire dtc_sfr_s   sfr,
	input wire dtc_ack_s   irq_ack,
	input wire dtc_pins_s  pins,
	input wire logic [7:0] sfr_rdata,
	input wire logic       t0_irq,
	input wire logic       t1_irq,
	input wire logic       ext_irq0_req,
	input wire logic       ext_irq1_req,
	input wire logic       t1_baud_tick
);
	logic [7:0] md_r;
	logic [7:0] ct_r;
	logic       wm;
	logic       wc;
	logic       sp;
	assign wm = sfr.wr && sfr.addr == DTC_ADDR_MODE;
	assign wc = sfr.wr && sfr.addr == DTC_ADDR_CTRL;
	assign sp = md_r[1:0] == 2'b11;
	// shadow copies of software-owned bits
	always_ff @(posedge clk) begin
		md_r <= !rst_n ? 8'h00 : wm ? sfr.wdata : md_r;
		ct_r <= !rst_n ? 8'h00 : wc ? sfr.wdata : ct_r;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	a_unmapped_read_zero:
		assert property (sfr.rd && (sfr.addr < DTC_ADDR_CTRL || sfr.addr > DTC_ADDR_T1_HI) |=> sfr_rdata == 8'h00)
			else $error("unmapped read not zero");
	a_rdata_holds:
		assert property (!sfr.rd |=> $stable(sfr_rdata)) else $error("read data moved");
	a_mode_readback:
		assert property (sfr.rd && sfr.addr == DTC_ADDR_MODE |=> sfr_rdata == $past(md_r))
			else $error("mode readback wrong");
	a_ctrl_sw_bits:
		assert property (sfr.rd && sfr.addr == DTC_ADDR_CTRL |=> {sfr_rdata[6], sfr_rdata[4], sfr_rdata[2],
			sfr_rdata[0]} == $past({ct_r[6], ct_r[4], ct_r[2], ct_r[0]})) else $error("control bits wrong");
	a_tick_sets_flag:
		assert property (t1_baud_tick && !sp |-> t1_irq) else $error("overflow flag not set");
	a_t1_ack_clears:
		assert property (irq_ack.t1_ovf && !sp |=> !t1_irq || t1_baud_tick) else $error("flag not cleared");
	a_t0_flag_holds:
		assert property (t0_irq && !irq_ack.t0_ovf && !wc |=> t0_irq) else $error("flag dropped");
	a_edge_flag_holds:
		assert property (ext_irq1_req && ct_r[2] && !irq_ack.x1 && !wc |=> ext_irq1_req)
			else $error("edge flag dropped");
	a_level_follows_pin:
		assert property ((!ct_r[0] && !wc && !pins.ext_irq0_pin_n)[*5] |-> ext_irq0_req)
			else $error("level flag missing");
	c_baud: cover property (t1_baud_tick);
	c_edge: cover property (ext_irq1_req && ct_r[2]);
	c_split: cover property (t1_irq && sp);
endmodule
bind dtc_timer dtc_timer_sva u_sva (.clk, .rst_n, .sfr, .irq_ack, .pins, .sfr_rdata, .t0_irq, .t1_irq,
	.ext_irq0_req, .ext_irq1_req, .t1_baud_tick);

// ---- test/dtc_timer_tb_top.sv ----
// testbench: registers, count timing and interrupt flags
module dtc_timer_tb_top
	import dtc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk;
	logic       rst_n;
	dtc_sfr_s   sfr;
	dtc_ack_s   ack;
	dtc_pins_s  want;
	dtc_pins_s  pins;
	logic [7:0] rdata;
	logic [7:0] v;
	logic [7:0] h;
	logic       i0;
	logic       i1;
	logic       x0;
	logic       x1;
	logic       bt;
	int         n_mismatch = 0;
	int         tests_run = 0;
	int         cyc = 0;
	int         n;
	int         k;
	dtc_pins_model PM (.clk, .want, .pins);
	dtc_timer DUT (.clk, .rst_n, .sfr, .irq_ack(ack), .pins, .sfr_rdata(rdata), .t0_irq(i0), .t1_irq(i1),
		.ext_irq0_req(x0), .ext_irq1_req(x1), .t1_baud_tick(bt));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk);
		sfr.wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdv(input logic [7:0] a, output logic [7:0] d);
		sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk);
		sfr.rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		rdv(a, d);
		chk({8'h00, d}, {8'h00, exp}, what);
	endtask
	task automatic pulse_ack(input dtc_ack_s a);
		ack <= a;
		@(posedge clk);
		ack <= '0;
		@(posedge clk);
	endtask
	task automatic wt(input int sel, output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while ((sel == 0 ? bt : sel == 1 ? i0 : i1) !== 1'b1 && c < 3000);
	endtask
	task automatic pulses(input int p);
		repeat (p) begin
			want.t1_count_pin <= 1'b0;
			repeat (8) @(posedge clk);
			want.t1_count_pin <= 1'b1;
			repeat (8) @(posedge clk);
		end
	endtask
	task automatic lat(input logic [7:0] md, input logic [7:0] la, input logic [7:0] lv, input logic [7:0] hv,
		input logic [7:0] ct, input int sel, input int c);
		int m;
		wr(DTC_ADDR_CTRL, 8'h00);
		wr(DTC_ADDR_MODE, md);
		wr(la, lv);
		wr(la + 8'h02, hv);
		wr(DTC_ADDR_CTRL, ct);
		wt(sel, m);
		chk(16'(m > 6 * c - 12 && m <= 6 * c), 16'h0001, "overflow latency");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sfr = '0;
		ack = '0;
		want = '1;
		rst_n = 1'b0;
		void'($urandom(94));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int a = 8'h88; a < 8'h8f; a++) rdc(8'(a), 8'h00, "reset value");
		for (int a = 8'h8a; a < 8'h90; a++) begin
			v = 8'($urandom);
			wr(8'(a), v);
			rdc(8'(a), a < 8'h8e ? v : 8'h00, "preset");
		end
		h = 8'($urandom_range(200, 250));
		wr(DTC_ADDR_MODE, 8'h22);
		for (int a = 8'h8a; a < 8'h8e; a++) wr(8'(a), h);
		wr(DTC_ADDR_CTRL, 8'h50);
		wt(0, n);
		wt(0, n);
		chk(16'(n), 16'(6 * (256 - h)), "reload t1");
		pulse_ack(4'b1010);
		wt(1, n);
		pulse_ack(4'b1010);
		wt(1, n);
		chk(16'(n + 2), 16'(6 * (256 - h)), "reload t0");
		k = $urandom_range(2, 20);
		lat(8'h01, DTC_ADDR_T0_LO, 8'(256 - k), 8'hff, 8'h10, 1, k);
		k = $urandom_range(2, 20);
		lat(8'h00, DTC_ADDR_T1_LO, {3'($urandom), 5'(32 - k)}, 8'hff, 8'h40, 2, k);
		k = $urandom_range(2, 20);
		lat(8'h03, DTC_ADDR_T0_LO, 8'(256 - k), 8'h00, 8'h10, 1, k);
		chk({15'h0000, i1}, 16'h0000, "split t1 flag");
		k = $urandom_range(2, 20);
		lat(8'h03, DTC_ADDR_T0_LO, 8'h00, 8'(256 - k), 8'h50, 2, k);
		wr(DTC_ADDR_MODE, 8'h30);
		wr(DTC_ADDR_CTRL, 8'h40);
		rdv(DTC_ADDR_T1_LO, v);
		repeat (60) @(posedge clk);
		rdc(DTC_ADDR_T1_LO, v, "halt");
		wr(DTC_ADDR_CTRL, 8'h00);
		wr(DTC_ADDR_MODE, 8'hd0);
		wr(DTC_ADDR_T1_LO, 8'h00);
		wr(DTC_ADDR_CTRL, 8'h40);
		k = $urandom_range(3, 9);
		pulses(k);
		want.ext_irq1_pin_n <= 1'b0;
		repeat (12) @(posedge clk);
		pulses(3);
		want.ext_irq1_pin_n <= 1'b1;
		wr(DTC_ADDR_CTRL, 8'h00);
		pulses(3);
		rdc(DTC_ADDR_T1_LO, 8'(k), "count pin");
		wr(DTC_ADDR_CTRL, 8'h04);
		want.ext_irq0_pin_n <= 1'b0;
		want.ext_irq1_pin_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk({14'h0000, x0, x1}, 16'h0003, "pins low");
		want.ext_irq0_pin_n <= 1'b1;
		want.ext_irq1_pin_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk({14'h0000, x0, x1}, 16'h0001, "pins high");
		pulse_ack(4'b0100);
		chk({15'h0000, x1}, 16'h0000, "edge ack");
		end_of_test();
	end
endmodule
